// >>> rtl/frt_pkg.sv
// Constants, field positions and types for the free-running capture/compare timer
package frt_pkg;
  // AXI4-Lite geometry
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h90;
  localparam logic [7:0]  IDX_FLAG_CTRL   = 8'h91;
  localparam logic [7:0]  IDX_COUNT_HI    = 8'h92;
  localparam logic [7:0]  IDX_COUNT_LO    = 8'h93;
  localparam logic [7:0]  IDX_COMPARE_HI  = 8'h94;
  localparam logic [7:0]  IDX_COMPARE_LO  = 8'h95;
  localparam logic [7:0]  IDX_TIMER_CTRL  = 8'h96;
  localparam logic [7:0]  IDX_OUT_CTRL    = 8'h97;
  localparam logic [7:0]  IDX_CAPTURE_HI  = 8'h98;  // Channel n upper byte at 98 + 2n
  localparam logic [7:0]  IDX_LAST        = 8'h9f;

  // Values after reset, the fixed output-control bits and the all-ones count
  localparam logic [15:0] COUNT_RESET        = 16'h0000;
  localparam logic [15:0] COMPARE_RESET      = 16'hffff;
  localparam logic [15:0] CAPTURE_RESET      = 16'h0000;
  localparam logic [7:0]  TIMER_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  OUT_CTRL_RESET     = 8'he0;
  localparam logic [7:0]  FLAG_CTRL_RESET    = 8'h00;
  localparam logic [7:0]  IRQ_ENABLE_RESET   = 8'h00;
  localparam logic [2:0]  OUT_CTRL_FIXED_ONE = 3'b111;
  localparam logic [15:0] COUNT_ALL_ONES     = 16'hffff;

  // Timer control fields
  localparam int TC_EDGE_A = 7;  // Edge select a..d at bits 7..4
  localparam int TC_BUF_A  = 3;
  localparam int TC_BUF_B  = 2;
  localparam int TC_CKS_LO = 0;  // Clock select at bits 1..0

  // Compare output control fields
  localparam int OC_SELECT = 4;
  localparam int OC_OE_A   = 3;
  localparam int OC_OE_B   = 2;
  localparam int OC_LVL_A  = 1;
  localparam int OC_LVL_B  = 0;

  // Flag/control fields; the enable register uses the same positions
  localparam int FL_CAP_A = 7;  // Capture flags a..d at bits 7..4
  localparam int FL_CMP_A = 3;
  localparam int FL_CMP_B = 2;
  localparam int FL_OVF   = 1;
  localparam int FL_CLR_A = 0;
  localparam logic [7:0] FLAG_MASK = 8'hfe;

  // Prescaler taps
  localparam int PRESCALE_W = 5;
  localparam int TAP_DIV2   = 0;
  localparam int TAP_DIV8   = 2;
  localparam int TAP_DIV32  = 4;

  typedef enum logic [1:0] {
    CKS_DIV2  = 2'b00,
    CKS_DIV8  = 2'b01,
    CKS_DIV32 = 2'b10,
    CKS_EXT   = 2'b11
  } frt_clk_sel_t;
endpackage : frt_pkg

// >>> rtl/frt_timer.sv
// Free-running 16-bit timer with two compare and four capture channels
//
// Function
// - Upper-byte write latches; lower write loads sixteen.
// - Upper-byte read latches lower byte for later.
// - Compare reads bypass the byte latch.
// - Internal tap falling edge advances the counter.
// - External pin rising edge advances the counter.
// - Compare match fires in last equal state.
// - Match drives compare pin to level bit.
// - Clear-on-match-A zeroes counter on match A.
// - Capture strobe on selected pin edge.
// - Upper-byte capture read delays strobe one cycle.
// - Buffered mode delays on either register read.
// - Opposite edges capture both; buffer flag only.
// - Capture strobe sets channel flag.
// - Rollover from all ones sets overflow flag.
// - Seven interrupt lines, each flag and enable.
// - Clear beats simultaneous counter lower write.
// - Counter lower write beats simultaneous increment.
// - Compare lower write suppresses simultaneous match.
// - Tap change high-to-low counts as increment.
// - Internal/external switch may also increment.
// - Clock select: 2, 8, 32, external rising.
// - Edge select zero falling, one rising.
// - Buffer enable makes C/D buffer of A/B.
// - Select bit steers shared compare address.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module frt_timer (
  // Clock, reset, clock enable
  input  wire  logic                       aclk,
  input  wire  logic                       aresetn,
  input  wire  logic                       ce,
  // AXI4-Lite write address and data
  input  wire  logic [frt_pkg::ADDR_W-1:0] awaddr,
  input  wire  logic [2:0]                 awprot,
  input  wire  logic                       awvalid,
  output logic                             awready,
  input  wire  logic [frt_pkg::DATA_W-1:0] wdata,
  input  wire  logic [3:0]                 wstrb,
  input  wire  logic                       wvalid,
  output logic                             wready,
  // AXI4-Lite write response
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire  logic                       bready,
  // AXI4-Lite read
  input  wire  logic [frt_pkg::ADDR_W-1:0] araddr,
  input  wire  logic [2:0]                 arprot,
  input  wire  logic                       arvalid,
  output logic                             arready,
  output logic [frt_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire  logic                       rready,
  // Timer pins
  input  wire  logic                       ext_count_clock_pin,
  input  wire  logic [3:0]                 capture_in,
  output logic                             compare_out_a,
  output logic                             compare_out_b,
  // Interrupt request lines
  output logic                             capture_a_irq,
  output logic                             capture_b_irq,
  output logic                             capture_c_irq,
  output logic                             capture_d_irq,
  output logic                             compare_a_irq,
  output logic                             compare_b_irq,
  output logic                             overflow_irq
);
  import frt_pkg::*;

  logic        wr_rdy;
  logic        rd_rdy;
  logic [7:0]  timer_control;
  logic [7:0]  compare_output_control;
  logic [7:0]  timer_flag_control;
  logic [7:0]  irq_enable;
  logic [7:0]  byte_latch;
  logic [15:0] free_run_count;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] cap_val [4];
  logic [PRESCALE_W-1:0] prescale;
  logic        ext_s1, ext_s2, src_prev;
  logic [3:0]  cap_s1, cap_s2, cap_s3;
  logic [3:0]  pend_cap, pend_flg;

  // Bus decode
  logic [7:0]  wr_idx, rd_idx;
  logic        wr_go, wr_map, wr_en, rd_go, rd_map;
  assign wr_idx = awaddr[9:2];
  assign rd_idx = araddr[9:2];
  assign wr_map = (awaddr[11:10] == 2'b00) && (wr_idx >= IDX_IRQ_ENABLE) && (wr_idx <= IDX_LAST);
  assign rd_map = (araddr[11:10] == 2'b00) && (rd_idx >= IDX_IRQ_ENABLE) && (rd_idx <= IDX_LAST);
  assign wr_go  = wr_rdy & awvalid & wvalid;
  assign rd_go  = rd_rdy & arvalid;
  assign wr_en  = wr_go & wr_map & wstrb[0];  // Only the low byte lane carries data
  assign awready = wr_rdy;
  assign wready  = wr_rdy;
  assign arready = rd_rdy;

  // Field views
  frt_clk_sel_t clk_sel;
  logic [3:0]   edge_select;
  logic         compare_reg_select;
  logic         clear_on_match_a;
  assign clk_sel            = frt_clk_sel_t'(timer_control[TC_CKS_LO +: 2]);
  assign edge_select        = timer_control[TC_EDGE_A -: 4];
  assign compare_reg_select = compare_output_control[OC_SELECT];
  assign clear_on_match_a   = timer_flag_control[FL_CLR_A];

  // Write strobes on the committing cycle
  logic w_hi16, w_cnt_lo, w_cmp_lo, w_cmp_lo_a, w_cmp_lo_b;
  assign w_hi16     = wr_en & ((wr_idx == IDX_COUNT_HI) || (wr_idx == IDX_COMPARE_HI) ||
                      ((wr_idx >= IDX_CAPTURE_HI) && !wr_idx[0]));
  assign w_cnt_lo   = wr_en & (wr_idx == IDX_COUNT_LO);
  assign w_cmp_lo   = wr_en & (wr_idx == IDX_COMPARE_LO);
  assign w_cmp_lo_a = w_cmp_lo & ~compare_reg_select;
  assign w_cmp_lo_b = w_cmp_lo & compare_reg_select;

  // Upper-byte reads of each capture register in the accepting cycle
  logic [3:0] rd_cap_hi;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rd_cap_hi[i] = rd_go & (rd_idx == IDX_CAPTURE_HI + 8'(2 * i));
    end
  end

  // AXI handshakes; ready is raised one cycle after both valids, so order does not matter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_rdy <= 1'b0;
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (ce) begin
      wr_rdy <= awvalid & wvalid & ~wr_rdy & ~bvalid;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data is registered; lower bytes of counter and captures come from the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_rdy <= 1'b0;
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= '0;
    end else if (ce) begin
      rd_rdy <= arvalid & ~rd_rdy & ~rvalid;
      if (rd_go) begin
        rvalid <= 1'b1;
        rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        rdata  <= {24'h000000, read_byte(rd_idx)};
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  function automatic logic [7:0] read_byte(input logic [7:0] idx);
    logic [15:0] cmp;
    cmp = compare_reg_select ? compare_value_b : compare_value_a;
    read_byte = 8'h00;
    if (idx == IDX_IRQ_ENABLE) read_byte = irq_enable;
    else if (idx == IDX_FLAG_CTRL) read_byte = timer_flag_control;
    else if (idx == IDX_COUNT_HI) read_byte = free_run_count[15:8];
    else if (idx == IDX_COUNT_LO) read_byte = byte_latch;
    else if (idx == IDX_COMPARE_HI) read_byte = cmp[15:8];
    else if (idx == IDX_COMPARE_LO) read_byte = cmp[7:0];
    else if (idx == IDX_TIMER_CTRL) read_byte = timer_control;
    else if (idx == IDX_OUT_CTRL) read_byte = compare_output_control;
    else if (idx >= IDX_CAPTURE_HI && idx <= IDX_LAST)
      read_byte = idx[0] ? byte_latch : cap_val[idx[2:1] - 2'd0][15:8];
  endfunction : read_byte

  // Byte latch: upper writes park data, upper reads of non-compare registers park low byte
  // Reversed or lone byte accesses therefore pair with stale latch content
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_latch <= 8'h00;
    end else if (ce) begin
      if (w_hi16) begin
        byte_latch <= wdata[7:0];
      end else if (rd_go && rd_idx == IDX_COUNT_HI) begin
        byte_latch <= free_run_count[7:0];
      end else if (|rd_cap_hi) begin
        byte_latch <= cap_val[rd_idx[2:1]][7:0];
      end
    end
  end

  // Plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control          <= TIMER_CTRL_RESET;
      compare_output_control <= OUT_CTRL_RESET;
      irq_enable             <= IRQ_ENABLE_RESET;
    end else if (ce && wr_en) begin
      if (wr_idx == IDX_TIMER_CTRL) timer_control <= wdata[7:0];
      if (wr_idx == IDX_OUT_CTRL) compare_output_control <= {OUT_CTRL_FIXED_ONE, wdata[4:0]};
      if (wr_idx == IDX_IRQ_ENABLE) irq_enable <= wdata[7:0] & FLAG_MASK;
    end
  end

  // Prescaler and external pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= '0;
      ext_s1   <= 1'b0;
      ext_s2   <= 1'b0;
    end else if (ce) begin
      prescale <= prescale + 1'b1;
      ext_s1   <= ext_count_clock_pin;
      ext_s2   <= ext_s1;
    end
  end

  // Selected source; the external pin is inverted so every source counts on a falling edge.
  // A single edge detector across selection changes makes a high-to-low swap count once.
  logic src_now, inc;
  always_comb begin
    unique case (clk_sel)
      CKS_DIV2:  src_now = prescale[TAP_DIV2];
      CKS_DIV8:  src_now = prescale[TAP_DIV8];
      CKS_DIV32: src_now = prescale[TAP_DIV32];
      CKS_EXT:   src_now = ~ext_s2;
    endcase
  end
  assign inc = src_prev & ~src_now;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev <= 1'b0;
    end else if (ce) begin
      src_prev <= src_now;
    end
  end

  // Compare match in the last equal state, just before the counter moves
  logic match_a, match_b, clr, ovf_evt;
  assign match_a = inc & (free_run_count == compare_value_a) & ~w_cmp_lo_a;
  assign match_b = inc & (free_run_count == compare_value_b) & ~w_cmp_lo_b;
  assign clr     = match_a & clear_on_match_a;
  assign ovf_evt = inc & ~clr & ~w_cnt_lo & (free_run_count == COUNT_ALL_ONES);

  // Counter: clear beats write, write beats increment
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_run_count <= COUNT_RESET;
    end else if (ce) begin
      if (clr) begin
        free_run_count <= COUNT_RESET;
      end else if (w_cnt_lo) begin
        free_run_count <= {byte_latch, wdata[7:0]};
      end else if (inc) begin
        free_run_count <= free_run_count + 16'h0001;
      end
    end
  end

  // Compare registers load all sixteen bits on the lower-byte write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_value_a <= COMPARE_RESET;
      compare_value_b <= COMPARE_RESET;
    end else if (ce) begin
      if (w_cmp_lo_a) compare_value_a <= {byte_latch, wdata[7:0]};
      if (w_cmp_lo_b) compare_value_b <= {byte_latch, wdata[7:0]};
    end
  end

  // Compare pins; a disabled output is held low and forgets its level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
    end else if (ce) begin
      if (!compare_output_control[OC_OE_A]) compare_out_a <= 1'b0;
      else if (match_a) compare_out_a <= compare_output_control[OC_LVL_A];
      if (!compare_output_control[OC_OE_B]) compare_out_b <= 1'b0;
      else if (match_b) compare_out_b <= compare_output_control[OC_LVL_B];
    end
  end

  // Capture pin synchronisers and edge detectors
  logic [3:0] rise, fall, cap_trig, flg_trig, blk, cap_stb, flg_stb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_s1 <= 4'h0;
      cap_s2 <= 4'h0;
      cap_s3 <= 4'h0;
    end else if (ce) begin
      cap_s1 <= capture_in;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end
  assign rise = cap_s2 & ~cap_s3;
  assign fall = ~cap_s2 & cap_s3;

  // Per pair: primary p (a or b) and partner q (c or d)
  genvar j;
  generate
    for (j = 0; j < 2; j++) begin : g_pair
      localparam int P = j;
      localparam int Q = j + 2;
      logic        buf_en, sel_p, sel_q, sel_q_on_p, diff;
      logic [15:0] cap_p, cap_q;
      assign buf_en     = timer_control[TC_BUF_A - j];
      assign sel_p      = edge_select[3 - P] ? rise[P] : fall[P];
      assign sel_q      = edge_select[3 - Q] ? rise[Q] : fall[Q];
      assign sel_q_on_p = edge_select[3 - Q] ? rise[P] : fall[P];
      assign diff       = edge_select[3 - P] ^ edge_select[3 - Q];
      assign cap_trig[P] = (buf_en & diff) ? (rise[P] | fall[P]) : sel_p;
      assign flg_trig[P] = sel_p;
      assign cap_trig[Q] = buf_en ? 1'b0 : sel_q;
      assign flg_trig[Q] = buf_en ? sel_q_on_p : sel_q;
      assign blk[P] = rd_cap_hi[P] | (buf_en & rd_cap_hi[Q]);
      assign blk[Q] = buf_en ? blk[P] : rd_cap_hi[Q];

      // Buffered capture shifts the old primary value into the partner first
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cap_p <= CAPTURE_RESET;
          cap_q <= CAPTURE_RESET;
        end else if (ce) begin
          if (cap_stb[P]) begin
            cap_p <= free_run_count;
            if (buf_en) cap_q <= cap_p;
          end else if (cap_stb[Q]) begin
            cap_q <= free_run_count;
          end
        end
      end
      assign cap_val[P] = cap_p;
      assign cap_val[Q] = cap_q;
    end
  endgenerate

  // One-cycle postponement while an upper byte is being read
  assign cap_stb = (cap_trig & ~blk) | pend_cap;
  assign flg_stb = (flg_trig & ~blk) | pend_flg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_cap <= 4'h0;
      pend_flg <= 4'h0;
    end else if (ce) begin
      pend_cap <= cap_trig & blk;
      pend_flg <= flg_trig & blk;
    end
  end

  // Sticky flags: software writes 0 to clear, and a same-cycle event still sets
  logic [7:0] flag_set, flag_keep;
  assign flag_set = {flg_stb[0], flg_stb[1], flg_stb[2], flg_stb[3],
                     match_a, match_b, ovf_evt, 1'b0};
  assign flag_keep = (wr_en && wr_idx == IDX_FLAG_CTRL) ? (wdata[7:0] | ~FLAG_MASK) : 8'hff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_flag_control <= FLAG_CTRL_RESET;
    end else if (ce) begin
      timer_flag_control <= ((timer_flag_control & flag_keep) | flag_set) & FLAG_MASK;
      if (wr_en && wr_idx == IDX_FLAG_CTRL) begin
        timer_flag_control[FL_CLR_A] <= wdata[FL_CLR_A];
      end else begin
        timer_flag_control[FL_CLR_A] <= clear_on_match_a;
      end
    end
  end

  // Interrupt lines follow flag and enable with one register stage
  logic [7:0] irq_now;
  assign irq_now = timer_flag_control & irq_enable;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_a_irq <= 1'b0;
      capture_b_irq <= 1'b0;
      capture_c_irq <= 1'b0;
      capture_d_irq <= 1'b0;
      compare_a_irq <= 1'b0;
      compare_b_irq <= 1'b0;
      overflow_irq  <= 1'b0;
    end else if (ce) begin
      capture_a_irq <= irq_now[FL_CAP_A];
      capture_b_irq <= irq_now[FL_CAP_A - 1];
      capture_c_irq <= irq_now[FL_CAP_A - 2];
      capture_d_irq <= irq_now[FL_CAP_A - 3];
      compare_a_irq <= irq_now[FL_CMP_A];
      compare_b_irq <= irq_now[FL_CMP_B];
      overflow_irq  <= irq_now[FL_OVF];
    end
  end

  // Protection bits and the upper lanes carry no meaning here
  logic unused_ok;
  assign unused_ok = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};
endmodule : frt_timer
`default_nettype wire

// >>> test/frt_timer_assertions.sv
// Bus and interrupt checker bound to the capture/compare timer top
`timescale 1ns/10ps
`default_nettype none
module frt_timer_checker
  import frt_pkg::*;
(
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  // Bus handshakes
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [1:0]        bresp,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic [DATA_W-1:0] rdata,
  // Interrupt lines
  input wire logic              overflow_irq,
  input wire logic              compare_a_irq,
  input wire logic              capture_a_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A take is only meaningful while the clock enable runs
  sequence wr_take;
    ce && awready && awvalid && wvalid;
  endsequence
  sequence rd_take;
    ce && arready && arvalid;
  endsequence

  wr_answer_a: assert property (wr_take |=> bvalid)
    else $error("write response missing after take");
  rd_answer_a: assert property (rd_take |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read answer missing or upper bits set");
  b_hold_a: assert property (ce && bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (ce && rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  ready_pair_a: assert property (awready == wready)
    else $error("address and data ready differ");
  wr_ready_cause_a: assert property ($rose(awready) |->
    $past(awvalid) && $past(wvalid) && !$past(bvalid))
    else $error("write ready without both valids");
  rd_busy_a: assert property (rvalid |-> !arready)
    else $error("read accepted while answer pending");
  reset_quiet_a: assert property (!$past(aresetn) |->
    !bvalid && !rvalid && !overflow_irq && !compare_a_irq && !capture_a_irq)
    else $error("outputs active right after reset");
endmodule : frt_timer_checker

bind frt_timer frt_timer_checker u_chk (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .overflow_irq, .compare_a_irq, .capture_a_irq);
`default_nettype wire

// >>> test/frt_ext_clk_model.sv
// Model of the external count clock source feeding the timer
`timescale 1ns/10ps
`default_nettype none
module frt_ext_clk_model (
  // Clock
  input wire logic aclk,
  // Count clock pin, still and low between bursts
  output logic     ext_count_clock_pin
);
  initial ext_count_clock_pin = 1'b0;

  // Two cycles each phase, so the synchroniser never misses a pulse
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge aclk);
      ext_count_clock_pin <= 1'b1;
      repeat (2) @(posedge aclk);
      ext_count_clock_pin <= 1'b0;
    end
    repeat (6) @(posedge aclk); // Sync and increment latency
  endtask : pulses
endmodule : frt_ext_clk_model
`default_nettype wire

// >>> test/free_running_capture_compare_timer_test.sv
// Self-checking bench for the free-running capture/compare timer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module free_running_capture_compare_timer_test;
  import frt_pkg::*;
  logic              aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, ext_pin;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        capture_in, wstrb;
  logic [1:0]        bresp, rresp;
  logic              awready, wready, bvalid, arready, rvalid, cmp_out_a, cmp_irq_a, ovf_irq;
  int                n_fail = 0;
  int                check_count = 0;

  frt_timer DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ext_count_clock_pin(ext_pin), .capture_in(capture_in),
    .compare_out_a(cmp_out_a), .compare_out_b(), .capture_a_irq(), .capture_b_irq(),
    .capture_c_irq(), .capture_d_irq(), .compare_a_irq(cmp_irq_a), .compare_b_irq(),
    .overflow_irq(ovf_irq));
  frt_ext_clk_model u_pins (.aclk(aclk), .ext_count_clock_pin(ext_pin));

  always #4 aclk = ~aclk;

  // One register write; valids held until ready, bready until bvalid
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin @(posedge aclk); t++; end while (awready !== 1'b1 && t < 50);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (bvalid !== 1'b1 && t < 50) begin @(posedge aclk); t++; end
    bready <= 1'b0;
    `CHK(bresp, RESP_OKAY)
    if (t >= 50) n_fail++;
  endtask : wr

  // One register read compared against the expected byte and response
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = 2'b00);
    int t;
    t = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin @(posedge aclk); t++; end while (arready !== 1'b1 && t < 50);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && t < 50) begin @(posedge aclk); t++; end
    rready <= 1'b0;
    `CHK(rdata, {24'h0, e})
    `CHK(rresp, er)
    if (t >= 50) n_fail++;
  endtask : rd

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    capture_in = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h258, 8'h00);
    rd(12'h25c, 8'he0);
    wr(12'h258, 8'h03);
    // Counter frozen on the idle pin while the byte pairs are checked
    wr(12'h248, 8'haa);
    wr(12'h24c, 8'h55);
    rd(12'h248, 8'haa);
    rd(12'h24c, 8'h55);
    wr(12'h250, 8'h12);
    wr(12'h254, 8'h34);
    wr(12'h25c, 8'h10);
    wr(12'h250, 8'h56);
    wr(12'h254, 8'h78);
    rd(12'h250, 8'h56);
    rd(12'h254, 8'h78);
    wr(12'h25c, 8'h0a);
    rd(12'h254, 8'h34);
    u_pins.pulses(5);
    rd(12'h248, 8'haa);
    rd(12'h24c, 8'h5a);
    // Match at 1234 with clear enabled: counter returns to zero
    wr(12'h248, 8'h12);
    wr(12'h24c, 8'h30);
    wr(12'h244, 8'h01);
    u_pins.pulses(5);
    rd(12'h248, 8'h00);
    rd(12'h24c, 8'h00);
    rd(12'h244, 8'h09);
    `CHK(cmp_out_a, 1'b1)
    wr(12'h240, 8'h08);
    repeat (3) @(posedge aclk);
    `CHK(cmp_irq_a, 1'b1)
    // Rollover from all ones
    wr(12'h244, 8'h00);
    wr(12'h240, 8'h02);
    wr(12'h248, 8'hff);
    wr(12'h24c, 8'hff);
    u_pins.pulses(1);
    rd(12'h244, 8'h02);
    `CHK(ovf_irq, 1'b1)
    rd(12'h248, 8'h00);
    rd(12'h24c, 8'h00);
    // A write without the low byte lane leaves the enables alone
    wstrb <= 4'he;
    wr(12'h240, 8'hff);
    wstrb <= 4'hf;
    rd(12'h240, 8'h02);
    // Pulses while the clock enable is low must not be counted
    ce <= 1'b0;
    u_pins.pulses(2);
    ce <= 1'b1;
    rd(12'h248, 8'h00);
    rd(12'h24c, 8'h00);
    // Channel a on rising edges, channel b left on falling edges
    wr(12'h248, 8'h43);
    wr(12'h24c, 8'h21);
    wr(12'h258, 8'h83);
    wr(12'h244, 8'h00);
    capture_in <= 4'h1;
    repeat (6) @(posedge aclk);
    capture_in <= 4'h3;
    repeat (6) @(posedge aclk);
    capture_in <= 4'h1;
    repeat (6) @(posedge aclk);
    rd(12'h260, 8'h43);
    rd(12'h264, 8'h21);
    rd(12'h268, 8'h43);
    rd(12'h26c, 8'h21);
    rd(12'h244, 8'hc0);
    // Buffer a into c with opposite edges: falling a captures, sets flag c only
    wr(12'h248, 8'h00);
    wr(12'h24c, 8'h77);
    wr(12'h244, 8'h00);
    wr(12'h258, 8'h8b);
    capture_in <= 4'h0;
    repeat (6) @(posedge aclk);
    rd(12'h270, 8'h43);
    rd(12'h274, 8'h21);
    rd(12'h260, 8'h00);
    rd(12'h264, 8'h77);
    rd(12'h244, 8'h20);
    rd(12'h000, 8'h00, RESP_SLVERR);
    report_and_stop();
  end
endmodule : free_running_capture_compare_timer_test
`default_nettype wire
